// ### sim/ccsc_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccsc_chipset_model (
   // Pins toward the controller
   output var ccsc_pkg::ccsc_pins_t pins
);
   // Fields that assert low; asserting one drives it to 0.
   localparam logic [11:0] LowMask = 12'hcfe;

   // A single-processor platform, so the quick start strap may be used.
   initial pins = LowMask;

   // The bench requests transitions of the defined state graph, plus a sleep request in Normal that must be ignored.
   task automatic drive(input int idx, input bit on);
      pins[idx] = on ^ LowMask[idx];
   endtask
endmodule
`default_nettype wire

// ### sim/ccsc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ccsc_ctrl_properties (
   // Clock and reset
   input wire logic                  mclk,
   input wire logic                  rst_n,
   // Watched signals
   input wire ccsc_pkg::ccsc_pins_t  pins,
   input wire ccsc_pkg::ccsc_state_t clkState,
   input wire logic                  coreClockRun,
   input wire logic                  quickStartSelected,
   input wire logic                  haltCycle,
   input wire logic                  stopGrantAck,
   input wire logic                  flushStart,
   input wire logic                  smmEntry,
   input wire logic                  addrBit20MaskActive,
   input wire logic                  probeModeActive
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Counts cycles spent in Deep Sleep after the bus clock came back.
   logic [11:0] deepCnt;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         deepCnt <= 12'h000;
      end else if (clkState == ccsc_pkg::CCSC_DEEP_SLEEP && !pins.busClockStopped) begin
         deepCnt <= deepCnt + 12'h001;
      end else begin
         deepCnt <= 12'h000;
      end
   end

   chk_run_normal: assert property (coreClockRun == (clkState == ccsc_pkg::CCSC_NORMAL))
      else $error("core clock state disagrees with Normal");
   chk_state_legal: assert property (clkState <= ccsc_pkg::CCSC_DEEP_SLEEP)
      else $error("undefined clock state");
   chk_halt_entry: assert property (haltCycle |-> clkState == ccsc_pkg::CCSC_AUTO_HALT
      && $past(clkState) == ccsc_pkg::CCSC_NORMAL) else $error("halt cycle without entry from Normal");
   chk_no_rehalt: assert property (clkState == ccsc_pkg::CCSC_AUTO_HALT
      && $past(clkState) != ccsc_pkg::CCSC_NORMAL |-> !haltCycle) else $error("halt cycle on re-entry");
   chk_ack_target: assert property (stopGrantAck |-> clkState == (quickStartSelected ?
      ccsc_pkg::CCSC_QUICK_START : ccsc_pkg::CCSC_STOP_GRANT)) else $error("acknowledge in wrong state");
   chk_smm_from_halt: assert property (smmEntry |-> clkState == ccsc_pkg::CCSC_NORMAL
      && $past(clkState) == ccsc_pkg::CCSC_AUTO_HALT) else $error("management entry not from halt");
   chk_flush_place: assert property (flushStart |-> clkState == ccsc_pkg::CCSC_AUTO_HALT
      && !haltCycle) else $error("flush started outside halt");
   chk_sleep_src: assert property (clkState == ccsc_pkg::CCSC_SLEEP && $past(clkState) != clkState
      |-> $past(clkState) inside {ccsc_pkg::CCSC_STOP_GRANT, ccsc_pkg::CCSC_DEEP_SLEEP})
      else $error("sleep entered from wrong state");
   chk_deep_src: assert property (clkState == ccsc_pkg::CCSC_DEEP_SLEEP && $past(clkState) != clkState
      |-> $past(clkState) inside {ccsc_pkg::CCSC_SLEEP, ccsc_pkg::CCSC_QUICK_START})
      else $error("deep sleep entered from wrong state");
   chk_strap_hold: assert property ($past(rst_n, 2) |-> $stable(quickStartSelected))
      else $error("strap selection changed after reset");
   chk_qs_exit: assert property (clkState == ccsc_pkg::CCSC_QUICK_START
      && $rose(pins.clockStopRequest_n) |-> ##[1:8] clkState != ccsc_pkg::CCSC_QUICK_START)
      else $error("quick start exit too slow");
   chk_deep_exit: assert property ($past(clkState) == ccsc_pkg::CCSC_DEEP_SLEEP
      && clkState != ccsc_pkg::CCSC_DEEP_SLEEP |-> deepCnt >= 12'h5dc) else $error("deep exit too early");
   chk_deep_bound: assert property (deepCnt <= 12'h5e1)
      else $error("deep exit too late");
   chk_track_halt: assert property ((clkState == ccsc_pkg::CCSC_AUTO_HALT && $stable(pins)) [*5]
      |-> addrBit20MaskActive == !pins.addrBit20Mask_n && probeModeActive == !pins.probeModeRequest_n)
      else $error("mask or probe not tracked in halt");

   cov_halt: cover property (haltCycle);
   cov_qs: cover property (stopGrantAck && clkState == ccsc_pkg::CCSC_QUICK_START);
   cov_deep: cover property ($past(clkState) == ccsc_pkg::CCSC_DEEP_SLEEP && clkState == ccsc_pkg::CCSC_SLEEP);
   cov_smm: cover property (smmEntry);
endmodule

bind ccsc_ctrl ccsc_ctrl_properties u_ccsc_ctrl_properties (.mclk(mclk), .rst_n(rst_n), .pins(pins),
   .clkState(clkState), .coreClockRun(coreClockRun), .quickStartSelected(quickStartSelected),
   .haltCycle(haltCycle), .stopGrantAck(stopGrantAck), .flushStart(flushStart), .smmEntry(smmEntry),
   .addrBit20MaskActive(addrBit20MaskActive), .probeModeActive(probeModeActive));
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int STOP = 11, STRAP = 10, IRQ = 9, NMI = 8, BUSINIT = 7, SINIT = 6;
   localparam int FLUSH = 5, MGMT = 4, SLEEP = 3, AMASK = 2, PROBE = 1, BCLK = 0;
   logic                   mclk;
   logic                   rst_n;
   logic                   clkEn;
   ccsc_pkg::ccsc_pins_t   pins;
   ccsc_pkg::ccsc_core_t   core;
   ccsc_pkg::ccsc_state_t  clkState;
   logic                   coreClockRun, quickStartSelected, haltCycle, stopGrantAck;
   logic                   flushStart, smmEntry, addrBit20MaskActive, probeModeActive;
   ccsc_pkg::ccsc_events_t serviceEvents, pendingEvents;
   int                     errorCnt, checkCount, haltSeen, ackSeen, flushSeen, smmSeen;

   ccsc_ctrl u_ccsc_ctrl (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .pins(pins), .core(core),
      .clkState(clkState), .coreClockRun(coreClockRun), .quickStartSelected(quickStartSelected),
      .haltCycle(haltCycle), .stopGrantAck(stopGrantAck), .flushStart(flushStart), .smmEntry(smmEntry),
      .serviceEvents(serviceEvents), .pendingEvents(pendingEvents),
      .addrBit20MaskActive(addrBit20MaskActive), .probeModeActive(probeModeActive));
   ccsc_chipset_model u_ccsc_chipset_model (.pins(pins));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Counted at the rising edge, before that edge's updates land.
   always @(posedge mclk) begin
      haltSeen += int'(haltCycle === 1'b1);
      ackSeen += int'(stopGrantAck === 1'b1);
      flushSeen += int'(flushStart === 1'b1);
      smmSeen += int'(smmEntry === 1'b1);
   end

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      checkCount++;
      if (!ok) begin
         errorCnt++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic pin(input int idx, input bit on);
      u_ccsc_chipset_model.drive(idx, on);
   endtask

   task automatic wait_state(input ccsc_pkg::ccsc_state_t s, input int lim, output int n);
      n = 0;
      while (clkState !== s) begin
         cyc(1);
         n++;
         if (n > lim) begin
            check(1'b0, "state wait expired");
            tally_and_finish();
         end
      end
   endtask

   task automatic do_reset(input bit qs);
      rst_n = 1'b0;
      pin(STRAP, qs);
      cyc(16);
      check(clkState === ccsc_pkg::CCSC_NORMAL && coreClockRun === 1'b1, "reset state");
      rst_n = 1'b1;
      cyc(2);
      pin(STRAP, !qs);
      cyc(4);
      check(quickStartSelected === qs, "strap selection");
   endtask

   task automatic go_halt();
      core.haltOpcode = 1'b1;
      cyc(1);
      core.haltOpcode = 1'b0;
      check(clkState === ccsc_pkg::CCSC_AUTO_HALT && haltCycle === 1'b1, "halt entry");
      check(coreClockRun === 1'b0, "core clock in halt");
   endtask

   task automatic leave_halt(input int ev);
      int n;
      pin(ev, 1'b1);
      wait_state(ccsc_pkg::CCSC_NORMAL, 6, n);
      check(n == 3, "halt break latency");
      pin(ev, 1'b0);
      cyc(4);
   endtask

   task automatic t_break();
      int ev[4] = '{IRQ, NMI, BUSINIT, SINIT};
      go_halt();
      cyc(1);
      clkEn = 1'b0;
      pin(IRQ, 1'b1);
      cyc(6);
      check(clkState === ccsc_pkg::CCSC_AUTO_HALT, "state frozen without enable");
      clkEn = 1'b1;
      leave_halt(IRQ);
      foreach (ev[i]) begin
         go_halt();
         leave_halt(ev[i]);
      end
   endtask

   task automatic t_stop(input bit qs);
      int n, a, h;
      go_halt();
      a = ackSeen;
      h = haltSeen;
      pin(STOP, 1'b1);
      wait_state(qs ? ccsc_pkg::CCSC_QUICK_START : ccsc_pkg::CCSC_STOP_GRANT, 6, n);
      cyc(1);
      check(ackSeen == a + 1, "stop acknowledge");
      core.snoopRequest = 1'b1;
      cyc(1);
      core.snoopRequest = 1'b0;
      check(clkState === ccsc_pkg::CCSC_SNOOP, "snoop entry");
      core.snoopDone = 1'b1;
      cyc(1);
      core.snoopDone = 1'b0;
      check(clkState === (qs ? ccsc_pkg::CCSC_QUICK_START : ccsc_pkg::CCSC_STOP_GRANT), "snoop return");
      if (qs) begin
         pin(BCLK, 1'b1);
         wait_state(ccsc_pkg::CCSC_DEEP_SLEEP, 6, n);
         pin(BCLK, 1'b0);
         wait_state(ccsc_pkg::CCSC_QUICK_START, 1600, n);
         check(n >= 1500 && n <= 1505, "deep exit to quick start");
      end
      pin(STOP, 1'b0);
      wait_state(ccsc_pkg::CCSC_AUTO_HALT, 8, n);
      cyc(1);
      check(haltSeen == h + 1, "no halt cycle after stop");
      leave_halt(IRQ);
   endtask

   task automatic t_smm();
      int n, s, h;
      go_halt();
      s = smmSeen;
      h = haltSeen;
      pin(MGMT, 1'b1);
      wait_state(ccsc_pkg::CCSC_NORMAL, 6, n);
      pin(MGMT, 1'b0);
      cyc(1);
      check(smmSeen == s + 1, "management entry");
      core.smmReturn = 1'b1;
      core.smmResumeHalt = 1'b1;
      cyc(1);
      core.smmReturn = 1'b0;
      core.smmResumeHalt = 1'b0;
      check(clkState === ccsc_pkg::CCSC_AUTO_HALT, "resume into halt");
      cyc(1);
      check(haltSeen == h + 1, "no halt cycle after return");
      leave_halt(IRQ);
   endtask

   task automatic t_flush();
      int f, h;
      go_halt();
      f = flushSeen;
      h = haltSeen;
      pin(FLUSH, 1'b1);
      cyc(4);
      check(flushSeen == f + 1 && clkState === ccsc_pkg::CCSC_AUTO_HALT, "flush start");
      pin(FLUSH, 1'b0);
      cyc(3);
      core.flushDone = 1'b1;
      cyc(1);
      core.flushDone = 1'b0;
      cyc(2);
      check(clkState === ccsc_pkg::CCSC_AUTO_HALT && haltSeen == h + 1, "flush return");
      pin(AMASK, 1'b1);
      pin(PROBE, 1'b1);
      cyc(4);
      check(addrBit20MaskActive === 1'b1 && probeModeActive === 1'b1, "mask tracked");
      pin(AMASK, 1'b0);
      pin(PROBE, 1'b0);
      cyc(4);
      check(addrBit20MaskActive === 1'b0 && probeModeActive === 1'b0, "mask released");
      leave_halt(IRQ);
   endtask

   task automatic t_sleep();
      int n;
      pin(SLEEP, 1'b1);
      cyc(6);
      check(clkState === ccsc_pkg::CCSC_NORMAL, "sleep ignored in Normal");
      pin(SLEEP, 1'b0);
      pin(STOP, 1'b1);
      wait_state(ccsc_pkg::CCSC_STOP_GRANT, 6, n);
      pin(SLEEP, 1'b1);
      wait_state(ccsc_pkg::CCSC_SLEEP, 6, n);
      pin(BCLK, 1'b1);
      wait_state(ccsc_pkg::CCSC_DEEP_SLEEP, 6, n);
      pin(BCLK, 1'b0);
      wait_state(ccsc_pkg::CCSC_SLEEP, 1600, n);
      check(n >= 1500 && n <= 1505, "deep sleep exit time");
      pin(SLEEP, 1'b0);
      wait_state(ccsc_pkg::CCSC_STOP_GRANT, 6, n);
      pin(NMI, 1'b1);
      cyc(4);
      check(pendingEvents === 5'h02, "event latched in stop grant");
      pin(NMI, 1'b0);
      pin(STOP, 1'b0);
      wait_state(ccsc_pkg::CCSC_NORMAL, 6, n);
      check(serviceEvents === 5'h02 && pendingEvents === 5'h00, "latched event handed over");
      pin(STOP, 1'b1);
      wait_state(ccsc_pkg::CCSC_STOP_GRANT, 6, n);
      pin(BUSINIT, 1'b1);
      wait_state(ccsc_pkg::CCSC_NORMAL, 6, n);
      pin(BUSINIT, 1'b0);
      pin(STOP, 1'b0);
      cyc(4);
      check(clkState === ccsc_pkg::CCSC_NORMAL, "back to Normal");
   endtask

   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      core = '0;
      errorCnt = 0;
      checkCount = 0;
      do_reset(1'b0);
      t_break();
      t_stop(1'b0);
      t_smm();
      t_flush();
      t_sleep();
      do_reset(1'b1);
      t_stop(1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ### verilog/ccsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsc_params.svh"

module ccsc_ctrl (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   // Pins and core
   input  wire ccsc_pkg::ccsc_pins_t  pins,
   input  wire ccsc_pkg::ccsc_core_t  core,
   // State
   output var  ccsc_pkg::ccsc_state_t clkState,
   output var  logic                  coreClockRun,
   output var  logic                  quickStartSelected,
   // Bus cycles and service
   output var  logic                  haltCycle,
   output var  logic                  stopGrantAck,
   output var  logic                  flushStart,
   output var  logic                  smmEntry,
   output var  ccsc_pkg::ccsc_events_t serviceEvents,
   output var  ccsc_pkg::ccsc_events_t pendingEvents,
   // Tracked levels
   output var  logic                  addrBit20MaskActive,
   output var  logic                  probeModeActive
);

   // -------------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------------
   ccsc_pkg::ccsc_pins_t pinS;

   ccsc_sync #(.WIDTH($bits(ccsc_pkg::ccsc_pins_t))) pinSync (
      .mclk  (mclk),
      .clkEn (clkEn),
      .d     (pins),
      .q     (pinS)
   );

   // Asserted meanings, with the low-active pins turned round.
   logic                   stopReq;
   logic                   busInit;
   logic                   sleepReq;
   logic                   clkStopped;
   ccsc_pkg::ccsc_events_t evLevel;

   always_comb begin
      stopReq       = ~pinS.clockStopRequest_n;
      busInit       = ~pinS.busInitRequest_n;
      sleepReq      = ~pinS.sleepRequest_n;
      clkStopped    = pinS.busClockStopped;
      evLevel.maskable_interrupt_request  = pinS.maskableInterruptRequest;
      evLevel.nmi   = pinS.nmiRequest;
      evLevel.init  = ~pinS.softInitRequest_n;
      evLevel.flush = ~pinS.cacheFlushRequest_n;
      evLevel.smi   = ~pinS.mgmtInterruptRequest_n;
   end

   // -------------------------------------------------------------------------
   // Strap capture
   // -------------------------------------------------------------------------
   // The synchroniser keeps sampling under reset, so the first enabled edge
   // after release sees the level that stood during reset.
   logic strapDone;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strapDone          <= 1'b0;
         quickStartSelected <= `CCSC_QS_RST;
      end else if (clkEn && !strapDone) begin
         strapDone          <= 1'b1;
         quickStartSelected <= ~pinS.quickStartStrap_n;
      end
   end

   // -------------------------------------------------------------------------
   // State machine
   // -------------------------------------------------------------------------
   ccsc_pkg::ccsc_state_t state;
   ccsc_pkg::ccsc_state_t next_state;
   ccsc_pkg::ccsc_state_t snoopReturn;
   ccsc_pkg::ccsc_state_t deepReturn;
   logic                  stopFromHalt;
   logic                  smmFromHalt;
   logic                  flushBusy;
   logic [`CCSC_DEEP_CNT_W-1:0] deepCount;

   localparam logic [`CCSC_DEEP_CNT_W-1:0] DeepLast =
      `CCSC_DEEP_CNT_W'(`CCSC_DEEP_EXIT_CYC - 1);

   logic haltBreak;
   logic stopTargetQs;
   logic toStop;
   logic stopLeave;

   always_comb begin
      haltBreak    = evLevel.maskable_interrupt_request | evLevel.nmi | evLevel.init | busInit;
      stopTargetQs = quickStartSelected;
      toStop       = (state == ccsc_pkg::CCSC_AUTO_HALT) && stopReq;
      stopLeave    = ((state == ccsc_pkg::CCSC_STOP_GRANT) ||
                      (state == ccsc_pkg::CCSC_QUICK_START)) && !stopReq;
   end

   always_comb begin
      next_state = state;
      case (state)
         ccsc_pkg::CCSC_NORMAL: begin
            if (core.haltOpcode) begin
               next_state = ccsc_pkg::CCSC_AUTO_HALT;
            end else if (smmFromHalt && core.smmReturn && core.smmResumeHalt) begin
               next_state = ccsc_pkg::CCSC_AUTO_HALT;
            end else if (stopReq) begin
               next_state = stopTargetQs ? ccsc_pkg::CCSC_QUICK_START
                                         : ccsc_pkg::CCSC_STOP_GRANT;
            end
         end
         ccsc_pkg::CCSC_AUTO_HALT: begin
            if (stopReq) begin
               next_state = stopTargetQs ? ccsc_pkg::CCSC_QUICK_START
                                         : ccsc_pkg::CCSC_STOP_GRANT;
            end else if (flushBusy) begin
               next_state = state;
            end else if (evLevel.smi) begin
               next_state = ccsc_pkg::CCSC_NORMAL;
            end else if (haltBreak) begin
               next_state = ccsc_pkg::CCSC_NORMAL;
            end else if (core.snoopRequest) begin
               next_state = ccsc_pkg::CCSC_SNOOP;
            end
         end
         ccsc_pkg::CCSC_STOP_GRANT: begin
            if (busInit) begin
               next_state = ccsc_pkg::CCSC_NORMAL;
            end else if (!stopReq) begin
               next_state = stopFromHalt ? ccsc_pkg::CCSC_AUTO_HALT
                                         : ccsc_pkg::CCSC_NORMAL;
            end else if (sleepReq) begin
               next_state = ccsc_pkg::CCSC_SLEEP;
            end else if (core.snoopRequest) begin
               next_state = ccsc_pkg::CCSC_SNOOP;
            end
         end
         ccsc_pkg::CCSC_QUICK_START: begin
            if (!stopReq) begin
               next_state = stopFromHalt ? ccsc_pkg::CCSC_AUTO_HALT
                                         : ccsc_pkg::CCSC_NORMAL;
            end else if (clkStopped) begin
               next_state = ccsc_pkg::CCSC_DEEP_SLEEP;
            end else if (core.snoopRequest) begin
               next_state = ccsc_pkg::CCSC_SNOOP;
            end
         end
         ccsc_pkg::CCSC_SNOOP: begin
            if (core.snoopDone) begin
               next_state = snoopReturn;
            end
         end
         ccsc_pkg::CCSC_SLEEP: begin
            if (clkStopped) begin
               next_state = ccsc_pkg::CCSC_DEEP_SLEEP;
            end else if (!sleepReq) begin
               next_state = ccsc_pkg::CCSC_STOP_GRANT;
            end
         end
         ccsc_pkg::CCSC_DEEP_SLEEP: begin
            if (!clkStopped && deepCount == DeepLast) begin
               next_state = deepReturn;
            end
         end
         default: begin
            next_state = ccsc_pkg::CCSC_NORMAL;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ccsc_pkg::CCSC_NORMAL;
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   // Where snoop and Deep Sleep return to.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         snoopReturn <= ccsc_pkg::CCSC_NORMAL;
         deepReturn  <= ccsc_pkg::CCSC_SLEEP;
      end else if (clkEn) begin
         if (next_state == ccsc_pkg::CCSC_SNOOP && state != ccsc_pkg::CCSC_SNOOP) begin
            snoopReturn <= state;
         end
         if (next_state == ccsc_pkg::CCSC_DEEP_SLEEP && state != ccsc_pkg::CCSC_DEEP_SLEEP) begin
            deepReturn <= state;
         end
      end
   end

   // Deep Sleep lock delay counts only while the bus clock runs again.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         deepCount <= '0;
      end else if (clkEn) begin
         if (state != ccsc_pkg::CCSC_DEEP_SLEEP || clkStopped) begin
            deepCount <= '0;
         end else if (deepCount != DeepLast) begin
            deepCount <= deepCount + `CCSC_DEEP_CNT_W'(1);
         end
      end
   end

   // Origin flags that decide whether a halt is re-entered silently.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stopFromHalt <= 1'b0;
         smmFromHalt  <= 1'b0;
      end else if (clkEn) begin
         if (toStop) begin
            stopFromHalt <= 1'b1;
         end else if (next_state == ccsc_pkg::CCSC_NORMAL) begin
            stopFromHalt <= 1'b0;
         end
         if (state == ccsc_pkg::CCSC_AUTO_HALT && next_state == ccsc_pkg::CCSC_NORMAL
             && evLevel.smi) begin
            smmFromHalt <= 1'b1;
         end else if (state == ccsc_pkg::CCSC_NORMAL && core.smmReturn) begin
            smmFromHalt <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Flush service in Auto Halt
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flushBusy  <= 1'b0;
         flushStart <= 1'b0;
      end else if (clkEn) begin
         flushStart <= 1'b0;
         if (flushBusy) begin
            if (core.flushDone) begin
               flushBusy <= 1'b0;
            end
         end else if (state == ccsc_pkg::CCSC_AUTO_HALT && !stopReq && evLevel.flush) begin
            flushBusy  <= 1'b1;
            flushStart <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Bus cycle strobes and state outputs
   // -------------------------------------------------------------------------
   // A halt cycle is only produced by the opcode; silent re-entries from
   // stop grant, management mode or a flush never raise it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         haltCycle    <= 1'b0;
         stopGrantAck <= 1'b0;
         smmEntry     <= 1'b0;
         clkState     <= ccsc_pkg::CCSC_NORMAL;
         coreClockRun <= 1'b1;
      end else if (clkEn) begin
         haltCycle    <= (state == ccsc_pkg::CCSC_NORMAL) && core.haltOpcode;
         stopGrantAck <= ((next_state == ccsc_pkg::CCSC_STOP_GRANT) ||
                          (next_state == ccsc_pkg::CCSC_QUICK_START)) &&
                         ((state == ccsc_pkg::CCSC_NORMAL) ||
                          (state == ccsc_pkg::CCSC_AUTO_HALT));
         smmEntry     <= (state == ccsc_pkg::CCSC_AUTO_HALT) &&
                         (next_state == ccsc_pkg::CCSC_NORMAL) && evLevel.smi;
         clkState     <= next_state;
         coreClockRun <= (next_state == ccsc_pkg::CCSC_NORMAL);
      end
   end

   // -------------------------------------------------------------------------
   // Event latching in Stop Grant
   // -------------------------------------------------------------------------
   // One occurrence of each event is kept and handed over on return to Normal.
   ccsc_pkg::ccsc_events_t evPrev;
   ccsc_pkg::ccsc_events_t evRise;

   always_comb begin
      evRise = evLevel & ~evPrev;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         evPrev        <= `CCSC_EV_RST;
         pendingEvents <= `CCSC_EV_RST;
         serviceEvents <= `CCSC_EV_RST;
      end else if (clkEn) begin
         evPrev        <= evLevel;
         serviceEvents <= `CCSC_EV_RST;
         if (state != ccsc_pkg::CCSC_NORMAL && next_state == ccsc_pkg::CCSC_NORMAL) begin
            serviceEvents <= pendingEvents;
            pendingEvents <= `CCSC_EV_RST;
         end else if (state == ccsc_pkg::CCSC_STOP_GRANT) begin
            pendingEvents <= pendingEvents | evRise;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Address mask and probe tracking
   // -------------------------------------------------------------------------
   // Frozen where inputs must not change (Quick Start, Snoop, Sleep, Deep Sleep).
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         addrBit20MaskActive <= 1'b0;
         probeModeActive     <= 1'b0;
      end else if (clkEn) begin
         if (state == ccsc_pkg::CCSC_NORMAL || state == ccsc_pkg::CCSC_AUTO_HALT ||
             state == ccsc_pkg::CCSC_STOP_GRANT) begin
            addrBit20MaskActive <= ~pinS.addrBit20Mask_n;
            probeModeActive     <= ~pinS.probeModeRequest_n;
         end
      end
   end

endmodule

`default_nettype wire

// ### verilog/ccsc_params.svh
`ifndef CCSC_PARAMS_SVH
`define CCSC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CCSC_MCLK_MHZ          50
`define CCSC_DEEP_EXIT_US      30
`define CCSC_DEEP_EXIT_CYC     (`CCSC_DEEP_EXIT_US * `CCSC_MCLK_MHZ)
`define CCSC_DEEP_CNT_W        11

// ----------------------------------------------------------------------------
// Field positions of the latched event vector
// ----------------------------------------------------------------------------
`define CCSC_EV_MASKABLE_INTERRUPT_REQUEST           0
`define CCSC_EV_NMI            1
`define CCSC_EV_INIT           2
`define CCSC_EV_FLUSH          3
`define CCSC_EV_SMI            4
`define CCSC_EV_W              5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCSC_EV_RST            5'h00
`define CCSC_QS_RST            1'h0

`endif

// ### verilog/ccsc_pkg.sv
package ccsc_pkg;

   typedef enum logic [2:0] {
      CCSC_NORMAL      = 3'h0,
      CCSC_AUTO_HALT   = 3'h1,
      CCSC_STOP_GRANT  = 3'h2,
      CCSC_QUICK_START = 3'h3,
      CCSC_SNOOP       = 3'h4,
      CCSC_SLEEP       = 3'h5,
      CCSC_DEEP_SLEEP  = 3'h6
   } ccsc_state_t;

   // Asynchronous pins; names ending in _n assert low.
   typedef struct packed {
      logic clockStopRequest_n;
      logic quickStartStrap_n;
      logic maskableInterruptRequest;
      logic nmiRequest;
      logic busInitRequest_n;
      logic softInitRequest_n;
      logic cacheFlushRequest_n;
      logic mgmtInterruptRequest_n;
      logic sleepRequest_n;
      logic addrBit20Mask_n;
      logic probeModeRequest_n;
      logic busClockStopped;
   } ccsc_pins_t;

   // Same-clock signals from the core and bus unit.
   typedef struct packed {
      logic haltOpcode;
      logic snoopRequest;
      logic snoopDone;
      logic flushDone;
      logic smmReturn;
      logic smmResumeHalt;
   } ccsc_core_t;

   typedef struct packed {
      logic smi;
      logic flush;
      logic init;
      logic nmi;
      logic maskable_interrupt_request;
   } ccsc_events_t;

endpackage

// ### verilog/ccsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------------
// The stages carry no reset so that a strap is still sampled while the system
// reset is held; the controller only trusts the output after release.
module ccsc_sync #(
   parameter int WIDTH = 1
) (
   // Clock
   input  wire logic             mclk,
   input  wire logic             clkEn,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge mclk) begin
      if (clkEn) begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule

`default_nettype wire
